/* common/hps_pkg.sv */
package hps_pkg;
  // control subaddresses and their reset contents
  localparam logic [7:0] ADDR_RATIO = 8'hA0;
  localparam logic [7:0] ADDR_ACL = 8'hA1;
  localparam logic [7:0] ADDR_GAIN = 8'hA2;
  localparam logic [7:0] RST_RATIO = 8'h01;
  localparam logic [7:0] RST_ACL = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h00;
  // field positions
  localparam int RATIO_LSB = 0;
  localparam int ACL_LSB = 0;
  localparam int SHIFT_LSB = 0;
  localparam int WEIGHT_BIT = 3;
  localparam int LUMA_PF_LSB = 4;
  localparam int CHROMA_PF_LSB = 6;
  // structure
  localparam int HIST_DEPTH = 64;
  localparam int PF_TAPS = 7;
  localparam int FINE_ONE = 1024;
  localparam int PHASE_BITS = 6;

  typedef enum logic [1:0] {
    PF_BYPASS = 2'h0,
    PF_121 = 2'h1,
    PF_CIF = 2'h2,
    PF_12221 = 2'h3
  } hps_pf_e;

  typedef enum logic {
    LINE_IDLE = 1'b0,
    LINE_RUN = 1'b1
  } hps_line_e;

  typedef struct packed {
    logic [7:0] ratio;
    logic [7:0] acl;
    logic [7:0] gain;
    logic [7:0] rdData;
    hps_line_e line;
    logic [5:0] phaseCnt;
    logic [1:0][PF_TAPS-1:0][7:0] raw;
    logic [1:0][HIST_DEPTH-1:0][7:0] hist;
    logic [9:0] dto;
    logic outValid;
    logic [1:0][7:0] outPix;
    logic [PHASE_BITS-1:0] outPhase;
  } hps_state_s;
endpackage

/* logic/hps_prescaler.sv */
`timescale 1ns/10ps
// How it works
// - total ratio is one over prescale ratio times 1024 over fine increment
// - each output carries a six-bit interpolation phase for the fine scaler
// - prescale ratio comes from the low six bits of its register
// - length field 0..63 selects accumulation over 1..64 pixels
// - weighting bit gives 1..1 or 1,2..2,1 pixel weights
// - dc gain is (weight+1) times length field plus (1 minus weight), except 1 at length field 0
// - accumulated sum is shifted right by the three-bit gain field
// - prefilter plus accumulator span at most 64 plus 7 taps
// - luma and chroma share timing and ratio, each has its own prefilter
// - first and last pixel of each line are unfiltered source copies
module hps_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // fine scaler increment
  input wire logic [12:0] fineScaleIncrement,
  // source pixels
  input wire logic inValid,
  input wire logic inLineStart,
  input wire logic inLineEnd,
  input wire logic [7:0] inLuma,
  input wire logic [7:0] inChroma,
  // prescaled pixels
  output logic outValid,
  output logic [7:0] outLuma,
  output logic [7:0] outChroma,
  output logic [5:0] outPhase
);

  hps_pkg::hps_state_s st_q, st_d;

  function automatic logic [7:0] clamp8(input int v);
    clamp8 = (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
  endfunction

  // window index 0 is newest; all shapes centre on index 3 so both paths keep equal delay
  function automatic logic [7:0] prefilt(input logic [hps_pkg::PF_TAPS-1:0][7:0] w,
                                         input logic [1:0] sel, input logic chroma);
    int v;
    int x [7];
    for (int k = 0; k < hps_pkg::PF_TAPS; k++) x[k] = int'(w[k]);
    case (hps_pkg::hps_pf_e'(sel))
      hps_pkg::PF_121: v = (x[2] + 2 * x[3] + x[4] + 2) >>> 2;
      hps_pkg::PF_CIF: begin
        // luma taps scaled by four to stay integer, both sets sum to 32
        if (chroma) v = (3 * x[1] + 8 * x[2] + 10 * x[3] + 8 * x[4] + 3 * x[5] + 16) >>> 5;
        else v = (-4 * x[0] + 4 * x[1] + 7 * x[2] + 18 * x[3] + 7 * x[4] + 4 * x[5] - 4 * x[6] + 16) >>> 5;
      end
      hps_pkg::PF_12221: v = (x[1] + 2 * (x[2] + x[3] + x[4]) + x[5] + 4) >>> 3;
      default: v = x[3];
    endcase
    prefilt = clamp8(v);
  endfunction

  // weighted sum over the newest len samples, then the renormalising shift
  function automatic logic [7:0] accum(input logic [hps_pkg::HIST_DEPTH-1:0][7:0] h,
                                       input int len, input logic wgt, input logic [2:0] sh);
    int s;
    s = 0;
    for (int k = 0; k < hps_pkg::HIST_DEPTH; k++) begin
      if (k < len) s += (wgt && k != 0 && k != len - 1) ? 2 * int'(h[k]) : int'(h[k]);
    end
    accum = clamp8(s >>> sh);
  endfunction

  function automatic hps_pkg::hps_line_e hps_hold(input logic endNow);
    hps_hold = endNow ? hps_pkg::LINE_IDLE : hps_pkg::LINE_RUN;
  endfunction

  logic [5:0] effRatio;
  logic [1:0] pfSel [2];
  logic emitNow;
  assign effRatio = (st_q.ratio[hps_pkg::RATIO_LSB +: 6] == 6'h00) ? 6'h01
                  : st_q.ratio[hps_pkg::RATIO_LSB +: 6];
  assign pfSel[0] = st_q.gain[hps_pkg::LUMA_PF_LSB +: 2];
  assign pfSel[1] = st_q.gain[hps_pkg::CHROMA_PF_LSB +: 2];
  assign emitNow = inValid && !inLineStart && !inLineEnd && st_q.line == hps_pkg::LINE_RUN
                 && st_q.phaseCnt == effRatio - 6'h01;

  always_comb begin
    logic [7:0] src [2];
    logic [1:0][hps_pkg::PF_TAPS-1:0][7:0] win;
    src[0] = inLuma;
    src[1] = inChroma;
    win = st_q.raw;
    st_d = st_q;
    st_d.outValid = 1'b0;
    st_d.rdData = 8'h00;
    if (regRdEn) begin
      case (regAddr)
        hps_pkg::ADDR_RATIO: st_d.rdData = st_q.ratio;
        hps_pkg::ADDR_ACL: st_d.rdData = st_q.acl;
        hps_pkg::ADDR_GAIN: st_d.rdData = st_q.gain;
        default: st_d.rdData = 8'h00;
      endcase
    end
    if (regWrEn) begin
      case (regAddr)
        hps_pkg::ADDR_RATIO: st_d.ratio = regWrData;
        hps_pkg::ADDR_ACL: st_d.acl = regWrData;
        hps_pkg::ADDR_GAIN: st_d.gain = regWrData;
        default: st_d.line = st_q.line;
      endcase
    end
    if (inValid && inLineStart) begin
      // prime the window with the first sample so the prefilters start at its level
      for (int p = 0; p < 2; p++) begin
        for (int k = 0; k < hps_pkg::PF_TAPS; k++) st_d.raw[p][k] = src[p];
        st_d.hist[p] = '0;
        st_d.outPix[p] = src[p];
      end
      st_d.phaseCnt = 6'h00;
      st_d.dto = 10'h000;
      st_d.outPhase = '0;
      st_d.outValid = 1'b1;
      st_d.line = hps_hold(inLineEnd);
    end else if (inValid && st_q.line == hps_pkg::LINE_RUN) begin
      for (int p = 0; p < 2; p++) begin
        win[p] = {st_q.raw[p][hps_pkg::PF_TAPS-2:0], src[p]};
        st_d.raw[p] = win[p];
        // history depth 64 plus the 7-tap window bounds the combined span
        st_d.hist[p] = {st_q.hist[p][hps_pkg::HIST_DEPTH-2:0], prefilt(win[p], pfSel[p], p == 1)};
      end
      if (inLineEnd) begin
        for (int p = 0; p < 2; p++) st_d.outPix[p] = src[p];
        st_d.outValid = 1'b1;
        st_d.outPhase = st_q.dto[9:4];
        st_d.line = hps_pkg::LINE_IDLE;
      end else if (emitNow) begin
        for (int p = 0; p < 2; p++) begin
          st_d.outPix[p] = accum(st_d.hist[p], int'(st_q.acl[hps_pkg::ACL_LSB +: 6]) + 1,
                                 st_q.gain[hps_pkg::WEIGHT_BIT], st_q.gain[hps_pkg::SHIFT_LSB +: 3]);
        end
        st_d.outValid = 1'b1;
        st_d.outPhase = st_q.dto[9:4];
        st_d.dto = st_q.dto + fineScaleIncrement[9:0];
        st_d.phaseCnt = 6'h00;
      end else begin
        st_d.phaseCnt = st_q.phaseCnt + 6'h01;
      end
    end
    // a new ratio restarts the count, else a smaller ratio could strand it above the match value
    if (regWrEn && regAddr == hps_pkg::ADDR_RATIO) st_d.phaseCnt = 6'h00;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.ratio <= hps_pkg::RST_RATIO;
      st_q.acl <= hps_pkg::RST_ACL;
      st_q.gain <= hps_pkg::RST_GAIN;
      st_q.line <= hps_pkg::LINE_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdData = st_q.rdData;
  assign outValid = st_q.outValid;
  assign outLuma = st_q.outPix[0];
  assign outChroma = st_q.outPix[1];
  assign outPhase = st_q.outPhase;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_acl_write: assert property (regWrEn && regAddr == hps_pkg::ADDR_ACL |=> st_q.acl == $past(regWrData))
    else $error("length register did not take the write");
  a_ratio_read: assert property (regRdEn && regAddr == hps_pkg::ADDR_RATIO && !regWrEn
                                 |=> regRdData == $past(st_q.ratio))
    else $error("ratio readback wrong");
  a_first_copy: assert property (inValid && inLineStart |=> outValid && outLuma == $past(inLuma)
                                 && outChroma == $past(inChroma))
    else $error("first pixel is not a source copy");
  a_last_copy: assert property (inValid && inLineEnd && !inLineStart && st_q.line == hps_pkg::LINE_RUN
                                |=> outValid && outChroma == $past(inChroma) && st_q.line == hps_pkg::LINE_IDLE)
    else $error("last pixel is not a source copy");
  a_decim_emit: assert property (emitNow |=> outValid ##1 (st_q.phaseCnt <= 6'h01))
    else $error("missing decimated output");
  a_no_early: assert property (inValid && st_q.line == hps_pkg::LINE_RUN && !inLineStart && !inLineEnd
                               && !emitNow |=> !outValid)
    else $error("output before ratio inputs");
  a_phase_bound: assert property (st_q.phaseCnt < effRatio)
    else $error("phase count beyond ratio");
  a_fine_phase: assert property (emitNow |=> outPhase == $past(st_q.dto[9:4])
                                 && st_q.dto == $past(st_q.dto) + $past(fineScaleIncrement[9:0]))
    else $error("fine phase step wrong");
  a_unity_path: assert property (emitNow && st_q.acl == 8'h00 && st_q.gain == 8'h00
                                 |=> outLuma == $past(st_q.raw[0][2]))
    else $error("unity bypass path altered the sample");
  a_idle_quiet: assert property (st_q.line == hps_pkg::LINE_IDLE && !(inValid && inLineStart) |=> !outValid)
    else $error("output outside a line");
  a_read_idle: assert property (!regRdEn |=> regRdData == 8'h00)
    else $error("read data not cleared between reads");
  a_ratio_restart: assert property (regWrEn && regAddr == hps_pkg::ADDR_RATIO |=> st_q.phaseCnt == 6'h00)
    else $error("ratio write did not restart the count");
  a_line_open: assert property (inValid && inLineStart && !inLineEnd |=> st_q.line == hps_pkg::LINE_RUN
                                && outPhase == 6'h00)
    else $error("line start did not open a line at phase zero");

  c_line_start: cover property (inValid && inLineStart ##1 outValid);
  c_decimate: cover property (emitNow && effRatio > 6'h02 && st_q.gain[hps_pkg::WEIGHT_BIT]);
  c_line_end: cover property (inValid && inLineEnd && st_q.line == hps_pkg::LINE_RUN);
  c_cif: cover property (emitNow && pfSel[0] == 2'h2);
  c_full_rate: cover property (emitNow && effRatio == 6'h01 && pfSel[0] == 2'h0);

endmodule // hps_prescaler

/* sim/hps_sink.sv */
`timescale 1ns/10ps
// fine scaler stand-in: logs every prescaled pixel it is handed
module hps_sink (
  // prescaled stream
  input wire logic clk,
  input wire logic outValid,
  input wire logic [7:0] outLuma,
  input wire logic [7:0] outChroma,
  input wire logic [5:0] outPhase
);
  logic [7:0] lumaQ[$];
  logic [7:0] chromaQ[$];
  logic [5:0] phaseQ[$];
  // taken on the edge so a one-cycle pulse is logged exactly once
  always @(posedge clk) begin
    if (outValid === 1'b1) begin
      lumaQ.push_back(outLuma);
      chromaQ.push_back(outChroma);
      phaseQ.push_back(outPhase);
    end
  end
endmodule // hps_sink

/* sim/hps_prescaler_tb.sv */
`timescale 1ns/10ps
module hps_prescaler_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [12:0] inc = 13'h012C;
  logic inValid = 1'b0;
  logic inLineStart = 1'b0;
  logic inLineEnd = 1'b0;
  logic [7:0] inLuma = 8'h00;
  logic [7:0] inChroma = 8'h00;
  logic outValid;
  logic [7:0] outLuma;
  logic [7:0] outChroma;
  logic [5:0] outPhase;
  int failures = 0;
  int checks_done = 0;
  int n;
  // cif at ratio 2, 1-2-1 at 3, 1-2-2-2-1 at 4, bypass at full rate; lengths stay below twice the ratio
  int rt[4] = '{2, 3, 4, 1};
  int cnt[4] = '{9, 6, 5, 16};
  logic [7:0] ac[4] = '{8'h02, 8'h02, 8'h04, 8'h00};
  logic [7:0] gn[4] = '{8'hAA, 8'h52, 8'hFB, 8'h00};
  always #2 clk = ~clk;
  hps_prescaler uut (.clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .fineScaleIncrement(inc), .inValid(inValid),
    .inLineStart(inLineStart), .inLineEnd(inLineEnd), .inLuma(inLuma), .inChroma(inChroma),
    .outValid(outValid), .outLuma(outLuma), .outChroma(outChroma), .outPhase(outPhase));
  hps_sink sink (.clk(clk), .outValid(outValid), .outLuma(outLuma), .outChroma(outChroma), .outPhase(outPhase));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 chk(what, exp, regRdData);
  endtask
  // constant line with a distinct last sample, so every dc-normalised filter returns the level
  task automatic line(input int len, input logic [7:0] v, input logic [7:0] c, input logic [7:0] e);
    sink.lumaQ.delete();
    sink.chromaQ.delete();
    sink.phaseQ.delete();
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      inValid <= 1'b1;
      inLineStart <= (i == 0);
      inLineEnd <= (i == len - 1);
      inLuma <= (i == len - 1) ? e : v;
      inChroma <= c;
    end
    @(posedge clk);
    inValid <= 1'b0;
    inLineEnd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // shifted weighted sum of a flat input, clamped to the pixel range
  function automatic logic [7:0] acc(input logic [7:0] v, input logic [7:0] g, input logic [7:0] a);
    int s;
    s = (((int'(g[3]) + 1) * int'(a[5:0]) + (1 - int'(g[3]))) * int'(v)) >> g[2:0];
    return (s > 255) ? 8'hFF : 8'(s);
  endfunction
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #60000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk("ratio reset", hps_pkg::ADDR_RATIO, 8'h01);
    rdchk("length reset", hps_pkg::ADDR_ACL, 8'h00);
    rdchk("gain reset", hps_pkg::ADDR_GAIN, 8'h00);
    wr(8'hA3, 8'h55);
    rdchk("unmapped", 8'hA3, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      wr(hps_pkg::ADDR_RATIO, 8'(rt[k]));
      wr(hps_pkg::ADDR_ACL, ac[k]);
      wr(hps_pkg::ADDR_GAIN, gn[k]);
      rdchk("gain readback", hps_pkg::ADDR_GAIN, gn[k]);
      line(16, 8'h40, 8'h80, 8'hC5);
      n = sink.lumaQ.size();
      chk("count", 8'(cnt[k]), 8'(n));
      if (n > 2) begin
        chk("first luma", 8'h40, sink.lumaQ[0]);
        chk("last luma", 8'hC5, sink.lumaQ[n-1]);
        chk("sum luma", acc(8'h40, gn[k], ac[k]), sink.lumaQ[n-2]);
        chk("sum chroma", acc(8'h80, gn[k], ac[k]), sink.chromaQ[n-2]);
        chk("start phase", 8'h00, {2'h0, sink.phaseQ[0]});
      end
      if (k == 0 && n > 2) chk("phase", {2'h0, inc[9:4]}, {2'h0, sink.phaseQ[2]});
      $display("test line %0d done", k);
    end
    // second reset in mid-run must bring ratio and gain back to their reset contents
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk("ratio after reset", hps_pkg::ADDR_RATIO, 8'h01);
    rdchk("gain after reset", hps_pkg::ADDR_GAIN, 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule // hps_prescaler_tb
